//--- common/hub_cfg_pkg.sv
// Constants, register indices and field layout of the sensor-hub configuration bank.
// Assumes a 32-bit AXI4-Lite register bus with byte address = 4 * register index.
package hub_cfg_pkg;

  localparam int          AXI_ADDR_W = 8;
  localparam int          IDX_W      = 6;
  localparam int          IDX_LSB    = 2;

  // Register indices; byte address is four times the index.
  localparam logic [5:0]  IDX_SENSOR2_REGISTER_POINTER = 6'h06;
  localparam logic [5:0]  IDX_SENSOR2_READ_SETUP       = 6'h07;
  localparam logic [5:0]  IDX_SENSOR3_BUS_TARGET       = 6'h08;
  localparam logic [5:0]  IDX_SENSOR3_REGISTER_POINTER = 6'h09;
  localparam logic [5:0]  IDX_SENSOR3_READ_SETUP       = 6'h0a;
  localparam logic [5:0]  IDX_SENSOR4_BUS_TARGET       = 6'h0b;
  localparam logic [5:0]  IDX_SENSOR4_REGISTER_POINTER = 6'h0c;
  localparam logic [5:0]  IDX_SENSOR4_READ_SETUP       = 6'h0d;
  localparam logic [5:0]  IDX_HUB_WRITE_BYTE           = 6'h0e;
  localparam logic [5:0]  IDX_HUB_CONTROL              = 6'h20;
  localparam logic [5:0]  IDX_HUB_STATUS               = 6'h21;

  localparam int          BANK_FIRST = 6;
  localparam int          BANK_LAST  = 14;
  localparam logic [7:0]  BANK_RESET = 8'h00;

  // Read setup fields.
  localparam int          DEC_HI = 7;
  localparam int          DEC_LO = 6;
  localparam int          CNT_HI = 2;
  localparam int          CNT_LO = 0;
  // Bus target fields.
  localparam int          ADDR_HI = 7;
  localparam int          ADDR_LO = 1;
  localparam int          EN_BIT  = 0;
  // Hub control fields.
  localparam int          CTRL_DIR_BIT  = 0;
  localparam int          CTRL_COND_BIT = 1;
  localparam int          CTRL_NUM_HI   = 3;
  localparam int          CTRL_NUM_LO   = 2;
  localparam logic [7:0]  CTRL_RESET    = 8'h00;

  // Number of sensors read: 00 one, 01 two, 10 three, 11 four.
  localparam logic [1:0]  NUM_TWO   = 2'h1;
  localparam logic [1:0]  NUM_THREE = 2'h2;

  // Decimation: every trigger, 2nd, 4th, 8th.
  localparam logic [1:0]  DEC_EVERY_1 = 2'h0;
  localparam logic [1:0]  DEC_EVERY_2 = 2'h1;
  localparam logic [1:0]  DEC_EVERY_4 = 2'h2;

  localparam logic        DIR_WRITE = 1'b0;

  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef enum logic {GATE_IDLE, GATE_WAIT} gate_state_t;

endpackage

//--- common/cond_read_if.sv
// Carries the first-sensor operation request and the conditioning read handshake.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ns
`default_nettype none
interface cond_read_if;
  logic       start;
  logic       direction;
  logic       conditioned;
  logic       cond_valid;
  logic [7:0] cond_byte;
  logic       request;
  logic       go;
  logic       abandon;
  logic       busy;

  modport gate (input start, direction, conditioned, cond_valid, cond_byte,
                output request, go, abandon, busy);
  modport owner (output start, direction, conditioned, cond_valid, cond_byte,
                 input request, go, abandon, busy);
endinterface
`default_nettype wire

//--- rtl/sample_decimator.sv
// Counts hub triggers and fires on every 1st, 2nd, 4th or 8th one.
// Assumes trigger is a one-cycle pulse on clk.
`timescale 1ns/1ns
`default_nettype none
module sample_decimator
  import hub_cfg_pkg::*;
(
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // Trigger and setting.
  input  wire logic       trigger,
  input  wire logic [1:0] rate,
  // Result.
  output logic            fire
);
  logic [2:0] count;
  logic [2:0] mask;

  always_comb begin
    unique case (rate)
      DEC_EVERY_1: mask = 3'h0;
      DEC_EVERY_2: mask = 3'h1;
      DEC_EVERY_4: mask = 3'h3;
      default:     mask = 3'h7;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      count <= 3'h0;
    end else if (trigger) begin
      count <= count + 3'h1;
    end
  end

  assign fire = trigger && ((count & mask) == 3'h0);
endmodule // sample_decimator
`default_nettype wire

//--- rtl/cond_read_gate.sv
// Runs the first-sensor operation, with an optional conditioning read first.
// Assumes the engine answers a conditioning request with one cond_valid pulse.
`timescale 1ns/1ns
`default_nettype none
module cond_read_gate
  import hub_cfg_pkg::*;
(
  // Clock and reset.
  input  wire logic clk,
  input  wire logic sys_rst,
  // Request and handshake.
  cond_read_if.gate cr
);
  gate_state_t state;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state      <= GATE_IDLE;
      cr.request <= 1'b0;
      cr.go      <= 1'b0;
      cr.abandon <= 1'b0;
    end else begin
      cr.go      <= 1'b0;
      cr.abandon <= 1'b0;
      unique case (state)
        GATE_IDLE: begin
          if (cr.start) begin
            if (cr.conditioned && cr.direction != DIR_WRITE) begin
              state      <= GATE_WAIT;
              cr.request <= 1'b1;
            end else begin
              cr.go <= 1'b1;
            end
          end
        end
        GATE_WAIT: begin
          if (cr.cond_valid) begin
            state      <= GATE_IDLE;
            cr.request <= 1'b0;
            cr.go      <= cr.cond_byte != 8'h00;
            cr.abandon <= cr.cond_byte == 8'h00;
          end
        end
      endcase
    end
  end

  assign cr.busy = state == GATE_WAIT;
endmodule // cond_read_gate
`default_nettype wire

//--- rtl/sensor_hub_slave_config_regs.sv
// Sensor-hub configuration bank behind an AXI4-Lite slave, with read slot planning.
// Assumes the hub engine runs on clk and pulses hub_trigger for one cycle.
//
// Notes on behaviour
// - Two-bit decimation for sensors 2 to 4, reset zero.
// - Low three bits give read count.
// - Sensor3 seven-bit bus address, upper bits.
// - Sensor3 address bit zero enables reads.
// - Sensor4 bus address and read enable.
// - Sensor3 register location, eight bits, reset zero.
// - Sensor4 register location, eight bits, reset zero.
// - Sensor2 register location, eight bits.
// - Byte written to sensor1, or conditioning location.
// - Direction bit: zero write, one read.
// - Conditioned read continues only on nonzero.
// - Two-bit field sets number of sensors.
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module sensor_hub_slave_config_regs
  import hub_cfg_pkg::*;
(
  // Clock and reset.
  input  wire logic                  clk,
  input  wire logic                  sys_rst,
  // AXI4-Lite write address.
  input  wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  // AXI4-Lite write data.
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  // AXI4-Lite write response.
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  // AXI4-Lite read address.
  input  wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  // AXI4-Lite read data.
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // Settings to the hub engine.
  output logic [7:0]                 sensor2_location,
  output logic [2:0]                 sensor2_read_count,
  output logic [6:0]                 sensor3_bus_address,
  output logic                       sensor3_read_enable,
  output logic [7:0]                 sensor3_location,
  output logic [2:0]                 sensor3_read_count,
  output logic [6:0]                 sensor4_bus_address,
  output logic                       sensor4_read_enable,
  output logic [7:0]                 sensor4_location,
  output logic [2:0]                 sensor4_read_count,
  output logic [7:0]                 hub_write_byte,
  output logic                       sensor1_direction,
  output logic                       conditioned_read,
  output logic [1:0]                 sensor_count,
  // Hub trigger and read slots.
  input  wire logic                  hub_trigger,
  output logic [3:0]                 read_slots,
  output logic                       read_slots_valid,
  // First-sensor operation.
  input  wire logic                  cond_data_valid,
  input  wire logic [7:0]            cond_data,
  output logic                       cond_read_request,
  output logic                       sensor1_go,
  output logic                       sensor1_abandon
);

  logic [7:0]       bank [BANK_FIRST:BANK_LAST];
  logic [7:0]       hub_control;
  logic             aw_held;
  logic [IDX_W-1:0] aw_index;
  logic             w_held;
  logic [7:0]       w_byte;
  logic             w_lane0;
  logic             do_write;
  logic             wr_in_bank;
  logic             wr_ok;
  logic [IDX_W-1:0] rd_index;
  logic [31:0]      rd_word;
  logic             rd_ok;
  logic             abandoned;
  logic [2:0]       fire;
  logic [3:0]       next_slots;

  cond_read_if cr ();

  // Write channel: address and data are taken in either order.
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign do_write      = aw_held && w_held && !s_axi_bvalid;
  assign wr_in_bank    = (int'(aw_index) >= BANK_FIRST) && (int'(aw_index) <= BANK_LAST);
  assign wr_ok         = wr_in_bank || (aw_index == IDX_HUB_CONTROL);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      aw_held  <= 1'b0;
      aw_index <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held  <= 1'b1;
      aw_index <= s_axi_awaddr[AXI_ADDR_W-1:IDX_LSB];
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      w_held  <= 1'b0;
      w_byte  <= 8'h00;
      w_lane0 <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held  <= 1'b1;
      w_byte  <= s_axi_wdata[7:0];
      w_lane0 <= s_axi_wstrb[0];
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Register bank: every bit is stored as written, reserved ones too.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = BANK_FIRST; i <= BANK_LAST; i++) begin
        bank[i] <= BANK_RESET;
      end
    end else if (do_write && wr_in_bank && w_lane0) begin
      bank[aw_index] <= w_byte;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hub_control <= CTRL_RESET;
    end else if (do_write && aw_index == IDX_HUB_CONTROL && w_lane0) begin
      hub_control <= w_byte;
    end
  end

  // Read channel: one word answered the cycle after the address is taken.
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_index      = s_axi_araddr[AXI_ADDR_W-1:IDX_LSB];

  always_comb begin
    rd_word = 32'h0000_0000;
    rd_ok   = 1'b1;
    if ((int'(rd_index) >= BANK_FIRST) && (int'(rd_index) <= BANK_LAST)) begin
      rd_word[7:0] = bank[rd_index];
    end else if (rd_index == IDX_HUB_CONTROL) begin
      rd_word[7:0] = hub_control;
    end else if (rd_index == IDX_HUB_STATUS) begin
      rd_word[7:0] = {2'b00, abandoned, cr.busy, read_slots};
    end else begin
      rd_ok = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Settings to the hub engine, straight from the bank and hub_control flip-flops.
  assign sensor2_location    = bank[IDX_SENSOR2_REGISTER_POINTER];
  assign sensor2_read_count  = bank[IDX_SENSOR2_READ_SETUP][CNT_HI:CNT_LO];
  assign sensor3_bus_address = bank[IDX_SENSOR3_BUS_TARGET][ADDR_HI:ADDR_LO];
  assign sensor3_read_enable = bank[IDX_SENSOR3_BUS_TARGET][EN_BIT];
  assign sensor3_location    = bank[IDX_SENSOR3_REGISTER_POINTER];
  assign sensor3_read_count  = bank[IDX_SENSOR3_READ_SETUP][CNT_HI:CNT_LO];
  assign sensor4_bus_address = bank[IDX_SENSOR4_BUS_TARGET][ADDR_HI:ADDR_LO];
  assign sensor4_read_enable = bank[IDX_SENSOR4_BUS_TARGET][EN_BIT];
  assign sensor4_location    = bank[IDX_SENSOR4_REGISTER_POINTER];
  assign sensor4_read_count  = bank[IDX_SENSOR4_READ_SETUP][CNT_HI:CNT_LO];
  assign hub_write_byte      = bank[IDX_HUB_WRITE_BYTE];
  assign sensor1_direction   = hub_control[CTRL_DIR_BIT];
  assign conditioned_read    = hub_control[CTRL_COND_BIT];
  assign sensor_count        = hub_control[CTRL_NUM_HI:CTRL_NUM_LO];

  // Decimation of the second to fourth sensors.
  sample_decimator dec2 (
    .clk     (clk),
    .sys_rst (sys_rst),
    .trigger (hub_trigger),
    .rate    (bank[IDX_SENSOR2_READ_SETUP][DEC_HI:DEC_LO]),
    .fire    (fire[0])
  );

  sample_decimator dec3 (
    .clk     (clk),
    .sys_rst (sys_rst),
    .trigger (hub_trigger),
    .rate    (bank[IDX_SENSOR3_READ_SETUP][DEC_HI:DEC_LO]),
    .fire    (fire[1])
  );

  sample_decimator dec4 (
    .clk     (clk),
    .sys_rst (sys_rst),
    .trigger (hub_trigger),
    .rate    (bank[IDX_SENSOR4_READ_SETUP][DEC_HI:DEC_LO]),
    .fire    (fire[2])
  );

  // Slots read on this trigger: sensor count, read enables and decimation.
  always_comb begin
    next_slots    = 4'h0;
    next_slots[0] = 1'b1;
    next_slots[1] = (sensor_count >= NUM_TWO) && fire[0];
    next_slots[2] = (sensor_count >= NUM_THREE) && sensor3_read_enable && fire[1];
    next_slots[3] = (sensor_count > NUM_THREE) && sensor4_read_enable && fire[2];
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      read_slots       <= 4'h0;
      read_slots_valid <= 1'b0;
    end else begin
      read_slots_valid <= hub_trigger;
      if (hub_trigger) begin
        read_slots <= next_slots;
      end
    end
  end

  // First-sensor operation and its conditioning read.
  assign cr.start       = hub_trigger;
  assign cr.direction   = sensor1_direction;
  assign cr.conditioned = conditioned_read;
  assign cr.cond_valid  = cond_data_valid;
  assign cr.cond_byte   = cond_data;

  cond_read_gate gate (
    .clk     (clk),
    .sys_rst (sys_rst),
    .cr      (cr.gate)
  );

  assign cond_read_request = cr.request;
  assign sensor1_go        = cr.go;
  assign sensor1_abandon   = cr.abandon;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      abandoned <= 1'b0;
    end else if (cr.abandon) begin
      abandoned <= 1'b1;
    end else if (cr.go) begin
      abandoned <= 1'b0;
    end
  end

endmodule // sensor_hub_slave_config_regs
`default_nettype wire

//--- sim/sensor_hub_slave_config_regs_asserts.sv
// Concurrent checks on the ports of the sensor-hub configuration bank.
// Assumes one clock domain and a bind placed in the bench top file.
`timescale 1ns/1ns
`default_nettype none
module sensor_hub_slave_config_regs_asserts
  import hub_cfg_pkg::*;
(
  // Clock and reset.
  input wire logic                  clk,
  input wire logic                  sys_rst,
  // Register bus.
  input wire logic                  s_axi_awvalid,
  input wire logic                  s_axi_awready,
  input wire logic                  s_axi_wvalid,
  input wire logic                  s_axi_wready,
  input wire logic                  s_axi_bvalid,
  input wire logic                  s_axi_bready,
  input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic                  s_axi_arvalid,
  input wire logic                  s_axi_arready,
  input wire logic [31:0]           s_axi_rdata,
  input wire logic [1:0]            s_axi_rresp,
  input wire logic                  s_axi_rvalid,
  // Hub side.
  input wire logic                  sensor3_read_enable,
  input wire logic                  sensor4_read_enable,
  input wire logic                  sensor1_direction,
  input wire logic                  conditioned_read,
  input wire logic [1:0]            sensor_count,
  input wire logic                  hub_trigger,
  input wire logic [3:0]            read_slots,
  input wire logic                  read_slots_valid,
  input wire logic                  cond_data_valid,
  input wire logic [7:0]            cond_data,
  input wire logic                  cond_read_request,
  input wire logic                  sensor1_go,
  input wire logic                  sensor1_abandon
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // Conditioning answer arrives while the request stands.
  sequence answer_zero;
    cond_read_request && cond_data_valid && cond_data == 8'h00;
  endsequence
  sequence answer_set;
    cond_read_request && cond_data_valid && cond_data != 8'h00;
  endsequence
  sequence gate_start;
    hub_trigger && !cond_read_request;
  endsequence

  a_read_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h00_0000)
    else $error("read answer missing or upper bits set");
  a_write_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write answer not two cycles after both taken");
  a_unmapped_error: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] > IDX_HUB_STATUS
    |=> s_axi_rresp == RESP_SLVERR) else $error("unmapped read not refused");
  a_slot_first: assert property (
    hub_trigger |=> read_slots_valid && read_slots[0]) else $error("no slot answer");
  a_count_few: assert property (
    hub_trigger && sensor_count < NUM_THREE |=> read_slots[3:2] == 2'h0)
    else $error("slot beyond sensor count");
  a_s3_disabled: assert property (
    hub_trigger && !sensor3_read_enable |=> !read_slots[2]) else $error("disabled sensor3 read");
  a_s4_disabled: assert property (
    hub_trigger && !sensor4_read_enable |=> !read_slots[3]) else $error("disabled sensor4 read");
  a_cond_request: assert property (
    gate_start and conditioned_read && sensor1_direction |=> cond_read_request && !sensor1_go)
    else $error("conditioning request missing");
  a_direct_go: assert property (
    gate_start and !(conditioned_read && sensor1_direction) |=> sensor1_go)
    else $error("direct operation did not start");
  a_cond_abandon: assert property (
    answer_zero |=> sensor1_abandon && !sensor1_go && !cond_read_request)
    else $error("zero answer not abandoned");
  a_cond_continue: assert property (
    answer_set |=> sensor1_go && !sensor1_abandon && !cond_read_request)
    else $error("nonzero answer did not continue");
endmodule // sensor_hub_slave_config_regs_asserts
`default_nettype wire

//--- sim/hub_engine_model.sv
// Model of the hub engine side: answers a conditioning request after a set delay.
// Assumes the request stays high until the cycle after the answer.
`timescale 1ns/1ns
`default_nettype none
module hub_engine_model (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // Bench settings.
  input  wire logic [3:0] answer_delay,
  input  wire logic [7:0] answer_byte,
  // Conditioning handshake.
  input  wire logic       cond_read_request,
  output logic            cond_data_valid,
  output logic [7:0]      cond_data
);
  logic [3:0] waited;

  // Data outside the answer cycle changes every cycle.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      waited <= 4'h0;
      cond_data_valid <= 1'b0;
      cond_data <= 8'h5A;
    end else if (cond_read_request && !cond_data_valid && waited == answer_delay) begin
      waited <= 4'h0;
      cond_data_valid <= 1'b1;
      cond_data <= answer_byte;
    end else begin
      waited <= (cond_read_request && !cond_data_valid) ? waited + 4'h1 : 4'h0;
      cond_data_valid <= 1'b0;
      cond_data <= ~cond_data;
    end
  end
endmodule // hub_engine_model
`default_nettype wire

//--- sim/sensor_hub_slave_config_regs_bench.sv
// Self-checking bench for the sensor-hub configuration bank.
// Assumes the design, its package and the engine model are compiled first.
`timescale 1ns/1ns
`default_nettype none
module sensor_hub_slave_config_regs_bench
  import hub_cfg_pkg::*;
;
  logic clk, sys_rst, hub_trigger, read_slots_valid, cond_data_valid;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [AXI_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb, read_slots, answer_delay;
  logic [1:0] s_axi_bresp, s_axi_rresp, sensor_count;
  logic [7:0] sensor2_location, sensor3_location, sensor4_location, hub_write_byte;
  logic [7:0] cond_data, answer_byte;
  logic [6:0] sensor3_bus_address, sensor4_bus_address;
  logic [2:0] sensor2_read_count, sensor3_read_count, sensor4_read_count;
  logic sensor3_read_enable, sensor4_read_enable, sensor1_direction, conditioned_read;
  logic cond_read_request, sensor1_go, sensor1_abandon;
  logic [7:0] tbl [6:14] = '{8'h5A, 8'h45, 8'hB3, 8'hC6, 8'h82, 8'h6E, 8'h3C, 8'hC7, 8'hE1};
  int num_errors, checks_done, i;

  sensor_hub_slave_config_regs u_sensor_hub_slave_config_regs (.*);
  hub_engine_model u_hub_engine_model (.*);

  always #25 clk = ~clk;

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One bus transfer, entered right after a rising edge.
  task automatic bus(input bit wr, input logic [5:0] idx, input logic [7:0] d,
                     output logic [31:0] rd, output logic [1:0] rs);
    int n;
    bit ta, tw, done;
    n = 0;
    done = 0;
    if (wr) begin
      s_axi_awaddr <= {idx, 2'b00};
      s_axi_wdata <= {24'h00_0000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
    end else begin
      s_axi_araddr <= {idx, 2'b00};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
    end
    while (!done && n < 40) begin
      @(negedge clk);
      ta = wr ? s_axi_awvalid && s_axi_awready : s_axi_arvalid && s_axi_arready;
      tw = s_axi_wvalid && s_axi_wready;
      done = wr ? s_axi_bvalid : s_axi_rvalid;
      rd = s_axi_rdata;
      rs = wr ? s_axi_bresp : s_axi_rresp;
      @(posedge clk);
      n++;
      if (ta && wr) s_axi_awvalid <= 1'b0;
      if (ta && !wr) s_axi_arvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
    @(posedge clk);
    if (!done) begin
      num_errors++;
      test_done();
    end
  endtask

  task automatic wchk(input logic [5:0] idx, input logic [7:0] d, input logic [1:0] er);
    logic [31:0] rd;
    logic [1:0] rs;
    bus(1'b1, idx, d, rd, rs);
    check("bresp", {30'h0, er}, {30'h0, rs});
  endtask

  task automatic rchk(input logic [5:0] idx, input logic [7:0] e, input logic [1:0] er);
    logic [31:0] rd;
    logic [1:0] rs;
    bus(1'b0, idx, 8'h00, rd, rs);
    check("rresp", {30'h0, er}, {30'h0, rs});
    if (er == RESP_OKAY) check("rdata", {24'h00_0000, e}, rd);
  endtask

  task automatic do_reset();
    sys_rst <= 1'b1;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
  endtask

  function automatic logic fires(int j, logic [1:0] r);
    return (j % (1 << r)) == 0;
  endfunction

  // Sixteen back-to-back triggers with expected slot patterns.
  task automatic burst(input logic [1:0] cnt, r2, r3, r4, input logic [1:0] en);
    logic [3:0] e;
    int j;
    wchk(IDX_HUB_CONTROL, {4'h0, cnt, 2'b00}, RESP_OKAY);
    wchk(IDX_SENSOR2_READ_SETUP, {r2, 6'h01}, RESP_OKAY);
    wchk(IDX_SENSOR3_READ_SETUP, {r3, 6'h02}, RESP_OKAY);
    wchk(IDX_SENSOR4_READ_SETUP, {r4, 6'h03}, RESP_OKAY);
    wchk(IDX_SENSOR3_BUS_TARGET, {7'h21, en[0]}, RESP_OKAY);
    wchk(IDX_SENSOR4_BUS_TARGET, {7'h22, en[1]}, RESP_OKAY);
    for (j = 0; j < 17; j++) begin
      hub_trigger <= (j < 16);
      @(negedge clk);
      if (j > 0) begin
        e[0] = 1'b1;
        e[1] = cnt >= NUM_TWO && fires(j - 1, r2);
        e[2] = cnt >= NUM_THREE && en[0] && fires(j - 1, r3);
        e[3] = cnt == 2'h3 && en[1] && fires(j - 1, r4);
        check("read_slots", {28'h0, e}, {28'h0, read_slots});
        check("slots_valid", 1, read_slots_valid);
      end
      @(posedge clk);
    end
    $display("test burst done");
  endtask

  // One first-sensor operation; exp is {abandon, go}.
  task automatic op(input logic [7:0] ctrl, input logic [7:0] b, input logic [1:0] exp);
    int n;
    logic [1:0] seen;
    wchk(IDX_HUB_CONTROL, ctrl, RESP_OKAY);
    answer_byte <= b;
    hub_trigger <= 1'b1;
    @(posedge clk);
    hub_trigger <= 1'b0;
    seen = 2'b00;
    n = 0;
    while (seen == 2'b00 && n < 40) begin
      @(negedge clk);
      seen = {sensor1_abandon, sensor1_go};
      @(posedge clk);
      n++;
    end
    check("go_abandon", {30'h0, exp}, {30'h0, seen});
    if (seen == 2'b00) test_done();
    $display("test operation done");
  endtask

  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hF;
    hub_trigger = 1'b0;
    answer_delay = 4'h0;
    answer_byte = 8'h00;
    do_reset();
    for (i = BANK_FIRST; i <= BANK_LAST; i++) rchk(i[5:0], BANK_RESET, RESP_OKAY);
    rchk(IDX_HUB_CONTROL, CTRL_RESET, RESP_OKAY);
    $display("test reset values done");
    for (i = BANK_FIRST; i <= BANK_LAST; i++) wchk(i[5:0], tbl[i], RESP_OKAY);
    wchk(IDX_HUB_CONTROL, 8'h0D, RESP_OKAY);
    for (i = BANK_FIRST; i <= BANK_LAST; i++) rchk(i[5:0], tbl[i], RESP_OKAY);
    check("s2loc", tbl[6], sensor2_location);
    check("s2cnt", tbl[7][CNT_HI:CNT_LO], sensor2_read_count);
    check("s3addr", tbl[8][ADDR_HI:ADDR_LO], sensor3_bus_address);
    check("s3en", tbl[8][EN_BIT], sensor3_read_enable);
    check("s3loc", tbl[9], sensor3_location);
    check("s3cnt", tbl[10][CNT_HI:CNT_LO], sensor3_read_count);
    check("s4addr", tbl[11][ADDR_HI:ADDR_LO], sensor4_bus_address);
    check("s4en", tbl[11][EN_BIT], sensor4_read_enable);
    check("s4loc", tbl[12], sensor4_location);
    check("s4cnt", tbl[13][CNT_HI:CNT_LO], sensor4_read_count);
    check("wbyte", tbl[14], hub_write_byte);
    check("ctrl", 4'hD, {sensor_count, conditioned_read, sensor1_direction});
    wchk(6'h3F, 8'hFF, RESP_SLVERR);
    rchk(6'h3F, 8'h00, RESP_SLVERR);
    wchk(IDX_HUB_STATUS, 8'hFF, RESP_SLVERR);
    rchk(IDX_HUB_WRITE_BYTE, tbl[14], RESP_OKAY);
    $display("test readback done");
    do_reset();
    rchk(IDX_SENSOR3_REGISTER_POINTER, BANK_RESET, RESP_OKAY);
    burst(2'h3, DEC_EVERY_2, DEC_EVERY_4, 2'h3, 2'b11);
    burst(2'h3, DEC_EVERY_1, 2'h3, DEC_EVERY_2, 2'b10);
    burst(NUM_TWO, DEC_EVERY_4, DEC_EVERY_1, DEC_EVERY_1, 2'b11);
    burst(2'h0, DEC_EVERY_1, DEC_EVERY_1, DEC_EVERY_1, 2'b01);
    op(8'h03, 8'h00, 2'b10);
    rchk(IDX_HUB_STATUS, 8'h21, RESP_OKAY);
    answer_delay <= 4'h6;
    op(8'h03, 8'h5C, 2'b01);
    rchk(IDX_HUB_STATUS, 8'h01, RESP_OKAY);
    op(8'h02, 8'h00, 2'b01);
    op(8'h01, 8'h00, 2'b01);
    test_done();
  end
endmodule // sensor_hub_slave_config_regs_bench

bind sensor_hub_slave_config_regs sensor_hub_slave_config_regs_asserts
  u_sensor_hub_slave_config_regs_asserts (.*);
`default_nettype wire
